// [pci_config_header_regs.sv]
/*
  Configuration header words 08h to 10h of a 1394 host controller
  function, with the initiator tenure counter and line size use.
  Assumes configuration cycles arrive decoded as one request each,
  synchronous to ref_clk, and that the initiator logic reports its
  own frame start, activity and grant.
*/
// Functional notes
// - Top class byte reads 0Ch, read-only
// - Subclass byte is a read-only constant
// - Programming model byte reads 10h
// - Low byte is fixed silicon version
// - Writable tenure limit, counts from frame
// - Expired tenure ends transfer at grant loss
// - Writable line size, cleared, used on bursts
// - Self-test byte always reads zero
// - Header type is type 0, bit7 zero
// - All ones write reads back FFFF_F800h
// - Base bits 31..11 writable, reset zero
// - Base bits 10..4 read zero
// - Base bit 3 reads zero, nonprefetchable
// - Base bits 2..1 read 00b
// - Base bit 0 reads zero, memory space
`include "pci_cfg_params.svh"
`timescale 1ns/10ps
`default_nettype none

module pci_config_header_regs #(
  // Value is arbitrary
  parameter logic [7:0] SILICON_VERSION = 8'h5A,
  parameter int TENURE_W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire pci_cfg_pkg::cfg_req_s cfg_req,
  output pci_cfg_pkg::cfg_rsp_s cfg_rsp,
  input wire logic own_frame_start,
  input wire logic own_xfer_active,
  input wire logic bus_gnt,
  input wire logic [3:0] own_cmd,
  output logic own_xfer_stop,
  output logic tenure_expired,
  output logic [7:0] line_burst_length,
  output logic [31:0] window_base_pointer,
  input wire logic [31:0] mem_addr,
  output logic window_hit
);

  logic [7:0] line_ff;
  logic [7:0] nxt_line;
  logic [TENURE_W-1:0] tenure_ff;
  logic [TENURE_W-1:0] nxt_tenure;
  logic [TENURE_W-1:0] tcnt_ff;
  logic [TENURE_W-1:0] nxt_tcnt;
  logic [`WINDOW_PTR_W-1:0] wptr_ff;
  logic [`WINDOW_PTR_W-1:0] nxt_wptr;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Access decode
  wire logic acc = ce && cfg_req.valid;
  wire logic wr = acc && cfg_req.write;
  wire logic rd = acc && !cfg_req.write;
  wire logic [7:0] dw_addr = {cfg_req.addr[7:2], 2'b00};
  wire logic hit_class = dw_addr == `OFS_CLASS_REV;
  wire logic hit_line = dw_addr == `OFS_LINE_TENURE;
  wire logic hit_base = dw_addr == `OFS_WINDOW_BASE;

  // Fixed classification word
  wire logic [31:0] class_word = {
    `FUNCTION_CATEGORY,
    `SUBCLASS_CODE,
    `PROGRAMMING_MODEL_CODE,
    SILICON_VERSION
  };

  // Line size, tenure, header type and self-test word
  wire logic [7:0] tenure_byte = 8'(tenure_ff);
  wire logic [31:0] line_word = {
    `SELF_TEST_FIELD,
    `HEADER_TYPE_CODE,
    tenure_byte,
    line_ff
  };

  // Window base word with fixed low bits
  wire logic [31:0] base_word = {wptr_ff, `WINDOW_LOW_BITS};

  // Read multiplexer; unmapped words read zero
  always_comb
  begin
    if (hit_class)
    begin
      nxt_rdata = class_word;
    end
    else if (hit_line)
    begin
      nxt_rdata = line_word;
    end
    else if (hit_base)
    begin
      nxt_rdata = base_word;
    end
    else
    begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  // Write strobes per writable byte
  wire logic wr_line = wr && hit_line && cfg_req.be[0];
  wire logic wr_tenure = wr && hit_line && cfg_req.be[1];
  wire logic wr_base = wr && hit_base;

  // Line size takes byte lane 0
  assign nxt_line = wr_line ? cfg_req.wdata[7:0] : line_ff;

  // Tenure limit takes byte lane 1
  assign nxt_tenure = wr_tenure ? TENURE_W'(cfg_req.wdata[15:8]) : tenure_ff;

  // Window pointer merges lanes 1 to 3; lane 0 is all fixed bits
  wire logic [31:0] base_mask = {
    {8{cfg_req.be[3]}},
    {8{cfg_req.be[2]}},
    {8{cfg_req.be[1]}},
    8'h00
  };
  wire logic [31:0] base_merged = (cfg_req.wdata & base_mask) | (base_word & ~base_mask);
  assign nxt_wptr = wr_base ? base_merged[31:`WINDOW_PTR_LSB] : wptr_ff;

  // Configuration registers
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      line_ff <= `LINE_RST;
      tenure_ff <= TENURE_W'(`TENURE_RST);
      wptr_ff <= `WINDOW_PTR_RST;
    end
    else if (ce)
    begin
      line_ff <= nxt_line;
      tenure_ff <= nxt_tenure;
      wptr_ff <= nxt_wptr;
    end
  end

  // Answer one cycle after each access, reads and writes alike
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_ff <= acc;
      rdata_ff <= rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign cfg_rsp.ack = ack_ff;
  assign cfg_rsp.rdata = rdata_ff;

  // Tenure counter restarts at frame start and saturates
  wire logic tcnt_max = &tcnt_ff;
  always_comb
  begin
    if (own_frame_start)
    begin
      nxt_tcnt = '0;
    end
    else if (own_xfer_active && !tcnt_max)
    begin
      nxt_tcnt = TENURE_W'(tcnt_ff + 1'b1);
    end
    else
    begin
      nxt_tcnt = tcnt_ff;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tcnt_ff <= '0;
    end
    else if (ce)
    begin
      tcnt_ff <= nxt_tcnt;
    end
  end

  // Expiry and stop request toward the initiator
  assign tenure_expired = own_xfer_active && !own_frame_start && (tcnt_ff >= tenure_ff);
  assign own_xfer_stop = tenure_expired && !bus_gnt;

  // Line size offered only for line-oriented commands
  wire logic line_cmd = (own_cmd == `CMD_READ_MULTIPLE) ||
    (own_cmd == `CMD_READ_LINE) ||
    (own_cmd == `CMD_WRITE_INVALIDATE);
  assign line_burst_length = line_cmd ? line_ff : 8'h00;

  // Window decode of the 2K register space
  assign window_base_pointer = base_word;
  assign window_hit = mem_addr[31:`WINDOW_PTR_LSB] == wptr_ff;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  class_read_a: assert property (
    rd && hit_class |=> rdata_ff[31:24] == 8'h0C)
  else $error("class byte wrong");

  subclass_const_a: assert property (
    rd && hit_class |=> rdata_ff[23:16] == `SUBCLASS_CODE)
  else $error("subclass changed");

  model_code_a: assert property (
    rd && hit_class |=> rdata_ff[15:8] == 8'h10)
  else $error("model code wrong");

  version_fixed_a: assert property (
    rd && hit_class |=> rdata_ff[7:0] == SILICON_VERSION)
  else $error("version wrong");

  tenure_write_a: assert property (
    wr_tenure ##1 !wr ##1 rd && hit_line
    |=> rdata_ff[15:8] == $past(cfg_req.wdata[15:8], 3))
  else $error("tenure not stored");

  tenure_restart_a: assert property (
    ce && own_frame_start |=> tcnt_ff == '0)
  else $error("count not restarted");

  stop_on_gnt_a: assert property (
    own_xfer_active && !own_frame_start && tcnt_ff >= tenure_ff && !bus_gnt
    |-> own_xfer_stop)
  else $error("no stop at grant loss");

  no_early_stop_a: assert property (
    own_xfer_stop |-> !bus_gnt && tcnt_ff >= tenure_ff)
  else $error("stop too early");

  line_reset_a: assert property (
    $past(srst) |-> line_ff == 8'h00)
  else $error("line size not cleared");

  line_use_a: assert property (
    own_cmd == `CMD_READ_LINE |-> line_burst_length == line_ff)
  else $error("line size unused");

  hdr_zero_a: assert property (
    rd && hit_line |=> rdata_ff[31:16] == 16'h0000)
  else $error("header word not zero");

  all_ones_a: assert property (
    wr_base && cfg_req.be == 4'hF && cfg_req.wdata == 32'hFFFF_FFFF
    ##1 !wr ##1 rd && hit_base |=> rdata_ff == 32'hFFFF_F800)
  else $error("size probe wrong");

  base_reset_a: assert property (
    $past(srst) |-> wptr_ff == '0)
  else $error("base not cleared");

  base_low_a: assert property (
    rd && hit_base |=> rdata_ff[10:0] == 11'h000)
  else $error("base low bits set");

  ro_write_a: assert property (
    wr && hit_class ##1 cfg_rsp.ack && !wr ##1 rd && hit_class
    |=> rdata_ff == {8'h0C, `SUBCLASS_CODE, 8'h10, SILICON_VERSION})
  else $error("read-only write changed value");

  ack_follow_a: assert property (
    ce && cfg_req.valid |=> cfg_rsp.ack)
  else $error("no answer");

  // Answers only for taken accesses, writes answer zero
  ack_pulse_a: assert property (
    ce && !cfg_req.valid |=> !cfg_rsp.ack)
  else $error("answer without access");

  write_rdata_a: assert property (
    wr |=> cfg_rsp.ack && cfg_rsp.rdata == 32'h0000_0000)
  else $error("write answer wrong");

  unmapped_zero_a: assert property (
    rd && !hit_class && !hit_line && !hit_base |=> rdata_ff == 32'h0000_0000)
  else $error("unmapped word not zero");

  // Writable fields keep what was written; fixed lane stays fixed
  line_write_a: assert property (
    wr_line ##1 !wr ##1 rd && hit_line
    |=> rdata_ff[7:0] == $past(cfg_req.wdata[7:0], 3))
  else $error("line size not stored");

  lane0_base_a: assert property (
    wr_base && cfg_req.be == 4'h1 |=> $stable(wptr_ff))
  else $error("fixed base lane written");

  // Tenure count edges: no early expiry, no wrap at the top
  expiry_low_a: assert property (
    own_xfer_active && tcnt_ff < tenure_ff |-> !tenure_expired)
  else $error("tenure expired early");

  count_sat_a: assert property (
    &tcnt_ff && !own_frame_start |=> &tcnt_ff)
  else $error("count wrapped");

  stop_hold_a: assert property (
    own_xfer_stop |-> tenure_expired)
  else $error("stop without expiry");

  line_idle_a: assert property (
    own_cmd < 4'hC |-> line_burst_length == 8'h00)
  else $error("line size on other command");

  // Low clock enable freezes every register
  ce_hold_a: assert property (
    !ce |=> $stable(line_ff) && $stable(tenure_ff) && $stable(wptr_ff) && $stable(tcnt_ff))
  else $error("state moved while disabled");

  size_probe_c: cover property (
    wr_base && cfg_req.wdata == 32'hFFFF_FFFF ##2 rd && hit_base);

  ce_freeze_c: cover property (
    !ce && cfg_req.valid);

  tenure_stop_c: cover property (
    own_frame_start ##[1:20] own_xfer_stop);

  line_burst_c: cover property (
    line_cmd && line_ff != 8'h00);

  window_hit_c: cover property (
    window_hit && wptr_ff != '0);

endmodule // pci_config_header_regs

`default_nettype wire

// [pci_cfg_params.svh]
/*
  Offsets, field positions, fixed values and reset values of the
  configuration header words 08h to 10h.
  Assumes inclusion by bare name from the register bank.
*/
`ifndef PCI_CFG_PARAMS_SVH
`define PCI_CFG_PARAMS_SVH

// Byte offsets in configuration space
`define OFS_CLASS_REV 8'h08
`define OFS_LINE_TENURE 8'h0C
`define OFS_HDR_SELFTEST 8'h0E
`define OFS_WINDOW_BASE 8'h10

// Fixed classification bytes
`define FUNCTION_CATEGORY 8'h0C
`define SUBCLASS_CODE 8'h00
`define PROGRAMMING_MODEL_CODE 8'h10

// Header type and self-test bytes
`define HEADER_TYPE_CODE 8'h00
`define SELF_TEST_FIELD 8'h00

// Window base field layout
`define WINDOW_PTR_LSB 11
`define WINDOW_PTR_W 21
`define WINDOW_LOW_BITS 11'h000

// Reset values of writable fields
`define LINE_RST 8'h00
`define TENURE_RST 8'h00
`define WINDOW_PTR_RST 21'h000000

// Bus commands that use the line size
`define CMD_READ_MULTIPLE 4'hC
`define CMD_READ_LINE 4'hE
`define CMD_WRITE_INVALIDATE 4'hF

`endif

// [pci_cfg_pkg.sv]
/*
  Types shared by the configuration register bank.
  Assumes the host side builds one request per configuration cycle.
*/
`default_nettype none

package pci_cfg_pkg;

  // One configuration access
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;

  // Read answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_s;

endpackage

`default_nettype wire

// [host_cfg_model.sv]
/*
  Host side model that issues one configuration cycle at a time.
  Assumes a single ref_clk and a registered one-cycle acknowledge.
*/
`timescale 1ns/10ps
`default_nettype none

module host_cfg_model (
  input wire logic ref_clk,
  output pci_cfg_pkg::cfg_req_s cfg_req,
  input wire pci_cfg_pkg::cfg_rsp_s cfg_rsp
);
  // Idle bus at time zero
  initial cfg_req = '0;

  // Hold the request over the taking edge, then release it and sample the answer
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
    input logic [31:0] wdata, output logic ack, output logic [31:0] rdata);
    @(posedge ref_clk);
    cfg_req <= '{valid: 1'b1, write: wr, addr: addr, be: be, wdata: wdata};
    @(posedge ref_clk);
    cfg_req <= '{valid: 1'b0, write: 1'b0, addr: ~addr, be: ~be, wdata: ~wdata};
    #1;
    ack = cfg_rsp.ack;
    rdata = cfg_rsp.rdata;
  endtask
endmodule // host_cfg_model

`default_nettype wire

// [tb_top.sv]
/*
  Self-checking bench for configuration words 08h to 10h.
  Assumes the package, the design and the host model are compiled first.
*/
`include "pci_cfg_params.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, (g), (e)); end end

module tb_top;
  // Value is arbitrary
  localparam logic [7:0] VER = 8'h3C;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic active = 1'b0;
  logic gnt = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic [31:0] maddr = 32'h0;
  logic [31:0] seed = 32'hD9BA;
  int err_total = 0;
  int n_tests = 0;
  logic ack;
  logic stop;
  logic expired;
  logic hit;
  logic [7:0] burst;
  logic [31:0] rd, line_w, base_w, v, d, wptr;
  pci_cfg_pkg::cfg_req_s req;
  pci_cfg_pkg::cfg_rsp_s rsp;

  pci_config_header_regs #(.SILICON_VERSION(VER)) dut (.ref_clk(ref_clk), .srst(srst),
    .ce(ce), .cfg_req(req), .cfg_rsp(rsp), .own_frame_start(start),
    .own_xfer_active(active), .bus_gnt(gnt), .own_cmd(cmd), .own_xfer_stop(stop),
    .tenure_expired(expired), .line_burst_length(burst), .window_base_pointer(wptr),
    .mem_addr(maddr), .window_hit(hit));
  host_cfg_model host (.ref_clk(ref_clk), .cfg_req(req), .cfg_rsp(rsp));

  // Clock and watchdog
  always #2 ref_clk = ~ref_clk;
  initial
  begin
    #40000;
    err_total++;
    finish_test();
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Byte-lane merge of a write into a reference copy, then the writable mask
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
    input logic [3:0] be, input logic [31:0] m);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[8*i +: 8] = n[8*i +: 8];
    return r & m;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] dat);
    host.access(1'b1, a, be, dat, ack, rd);
    `CHK(ack, 1'b1)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.access(1'b0, a, 4'hF, 32'h0, ack, rd);
    `CHK({ack, rd}, {1'b1, e})
  endtask

  // Frame start, count up to the limit, then drop the grant
  task automatic tenure(input logic [7:0] lim, input logic g);
    wr(`OFS_LINE_TENURE, 4'h2, {16'h0, lim, 8'h0});
    @(posedge ref_clk);
    start <= 1'b1;
    active <= 1'b1;
    gnt <= g;
    @(posedge ref_clk);
    start <= 1'b0;
    for (int k = 0; k <= lim; k++)
    begin
      #1;
      `CHK({expired, stop}, {k == lim, k == lim && !g})
      @(posedge ref_clk);
    end
    gnt <= 1'b0;
    #1;
    `CHK({expired, stop}, 2'b11)
    @(posedge ref_clk);
    active <= 1'b0;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(`OFS_CLASS_REV, {8'h0C, 8'h00, 8'h10, VER});
    wr(`OFS_CLASS_REV, 4'hF, 32'hFFFF_FFFF);
    rd_chk(`OFS_CLASS_REV, {8'h0C, 8'h00, 8'h10, VER});
    rd_chk(`OFS_LINE_TENURE, 32'h0);
    rd_chk(`OFS_WINDOW_BASE, 32'h0);
    rd_chk(8'h14, 32'h0);
    $display("test reset done");
    wr(`OFS_WINDOW_BASE, 4'hF, 32'hFFFF_FFFF);
    rd_chk(`OFS_WINDOW_BASE, 32'hFFFF_F800);
    base_w = 32'hFFFF_F800;
    line_w = 32'h0;
    for (int i = 0; i < 40; i++)
    begin
      v = rnd();
      d = rnd();
      if (i[0])
      begin
        wr(`OFS_WINDOW_BASE | {6'h0, v[5:4]}, v[3:0], d);
        base_w = merge(base_w, d, v[3:0], 32'hFFFF_F800);
        rd_chk(`OFS_WINDOW_BASE, base_w);
        `CHK(wptr, base_w)
        @(posedge ref_clk);
        maddr <= {base_w[31:11] ^ {20'h0, v[6]}, d[10:0]};
        #1;
        `CHK(hit, !v[6])
      end
      else
      begin
        wr(`OFS_LINE_TENURE | {6'h0, v[5:4]}, v[3:0], d);
        line_w = merge(line_w, d, v[3:0], 32'h0000_FFFF);
        rd_chk(`OFS_LINE_TENURE, line_w);
      end
    end
    $display("test random access done");
    wr(`OFS_LINE_TENURE, 4'h1, 32'h0000_00A5);
    for (int c = 0; c < 16; c++)
    begin
      @(posedge ref_clk);
      cmd <= c[3:0];
      #1;
      `CHK(burst, (c > 11 && c != 13) ? 8'hA5 : 8'h00)
    end
    // A write while the clock enable is low is neither taken nor answered
    @(posedge ref_clk);
    ce <= 1'b0;
    host.access(1'b1, `OFS_LINE_TENURE, 4'h1, 32'h0000_005A, ack, rd);
    `CHK(ack, 1'b0)
    @(posedge ref_clk);
    ce <= 1'b1;
    rd_chk(`OFS_LINE_TENURE, {16'h0, line_w[15:8], 8'hA5});
    tenure(8'h00, 1'b1);
    tenure(8'h01, 1'b0);
    for (int n = 0; n < 4; n++)
    begin
      v = rnd();
      tenure({5'h0, v[2:0]} + 8'h02, v[3]);
    end
    // Top limit: the count saturates and stays expired
    tenure(8'hFF, 1'b1);
    $display("test tenure done");
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd_chk(`OFS_LINE_TENURE, 32'h0);
    rd_chk(`OFS_WINDOW_BASE, 32'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
